//--- logic/shs_defines.svh
/*
 shs_defines.svh: offsets, field positions, reset values and timing of the
 homing sequencer. Assumes inclusion by shs_pkg, shs_top and tb_top only.
*/
// Overview of operation
// - trigger mode 0 disables homing; go input ignored.
// - trigger mode 1 starts homing on go input level.
// - trigger mode 2 starts homing on go input rising edge.
// - trigger mode 3 homes once at first servo-on after power-up.
// - later servo-on events never restart automatic homing.
// - reference modes 0/1: move ccw/cw, detector rising edge is reference.
// - reference mode 2: ccw, ccw limit falling edge; its inhibit suspended.
// - reference mode 3: cw, cw limit falling edge; its inhibit suspended.
// - reference modes 4/5: move ccw/cw, index pulse is reference.
// - origin mode 0: reverse at second speed, next index is origin.
// - origin mode 1: continue at second speed, next index is origin.
// - origin mode 2: reference point itself is the origin.
// - homing starts only with servo-on; normal commands then suspended.
// - on completion clear position and deviation, then assert done.
// - level mode: done held until go input falls.
// - edge and auto modes: done drops after done delay.
// - post mode 0: hold at origin, reject commands until done drops.
// - post mode 1: resume commands right after completion.
// - level mode: servo-off, warning or go low aborts, no done.
// - edge/auto modes: servo-off or warning aborts, no done.
// - final origin is found position plus upper*10000 plus lower.
// - speed changes follow acceleration and deceleration times.
`ifndef SHS_DEFINES_SVH
`define SHS_DEFINES_SVH
`define SHS_A_CTRL     8'h00
`define SHS_A_SPEED    8'h04
`define SHS_A_RAMP     8'h08
`define SHS_A_DELAY    8'h0C
`define SHS_A_OFFSET   8'h10
`define SHS_A_STATUS   8'h14
`define SHS_A_ORIGIN   8'h18
`define SHS_F_TRIG     1:0
`define SHS_F_REFM     4:2
`define SHS_F_ORGM     6:5
`define SHS_F_RESUME   7
`define SHS_F_LO       11:0
`define SHS_F_HI       27:16
`define SHS_F_RLO      14:0
`define SHS_F_RHI      30:16
`define SHS_F_OLO      15:0
`define SHS_F_OHI      31:16
`define SHS_F_FLAGS    5:0
`define SHS_F_FSM      10:8
`define SHS_F_SPD      28:16
`define SHS_TRIG_OFF   2'h0
`define SHS_TRIG_LEVEL 2'h1
`define SHS_TRIG_EDGE  2'h2
`define SHS_TRIG_AUTO  2'h3
`define SHS_ORG_BACK   2'h0
`define SHS_ORG_FWD    2'h1
`define SHS_REF_MAX    3'h5
`define SHS_RST_SPD1   12'h1F4
`define SHS_RST_SPD2   12'h032
`define SHS_RST_DLY    12'h064
`define SHS_OFF_SCALE  32'sh2710
`define SHS_P_GO       0
`define SHS_P_SON      1
`define SHS_P_REF      2
`define SHS_P_COUNTERCLOCKWISE_LIMIT_INPUT     3
`define SHS_P_CWL      4
`define SHS_P_IDX      5
`define SHS_NPIN       6
`define SHS_CLK_NS     10
`define SHS_TICK_NS    1000
`define SHS_CYC_PER_US ((`SHS_TICK_NS + `SHS_CLK_NS - 1) / `SHS_CLK_NS)
`define SHS_US_PER_MS  1000
`endif

//--- logic/shs_pkg.sv
/*
 shs_pkg.sv: types of the homing sequencer.
 Assumes shs_defines.svh on the include path.
*/
`default_nettype none
`include "shs_defines.svh"
package shs_pkg;
   typedef logic signed [12:0] shs_speed_t;
   typedef enum logic [2:0] {
      SHS_IDLE  = 3'h0,
      SHS_REF   = 3'h1,
      SHS_ORG   = 3'h3,
      SHS_CLEAR = 3'h2,
      SHS_DONE  = 3'h6
   } shs_fsm_t;
   typedef struct packed {
      shs_fsm_t              state;
      logic [`SHS_NPIN-1:0]  sync1;
      logic [`SHS_NPIN-1:0]  sync2;
      logic [`SHS_NPIN-1:0]  prev;
      logic [1:0]            trig;
      logic [2:0]            refm;
      logic [1:0]            orgm;
      logic                  resume;
      logic [11:0]           spd1;
      logic [11:0]           spd2;
      logic [14:0]           acc;
      logic [14:0]           dec;
      logic [11:0]           dly;
      logic [15:0]           offu;
      logic [15:0]           offl;
      logic                  auto_used;
      logic                  dir;
      logic [6:0]            us_cnt;
      logic [9:0]            ms_cnt;
      logic [14:0]           ramp_cnt;
      logic [11:0]           dly_cnt;
      shs_speed_t            speed;
      logic                  done;
      logic                  clr;
      logic                  busy;
      logic                  cmd_en;
      logic                  ccw_sup;
      logic                  cw_sup;
      logic [31:0]           origin;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } shs_state_t;
endpackage
`default_nettype wire

//--- logic/shs_top.sv
/*
 shs_top.sv: homing sequencer of a servo drive with an apb register file.
 Assumes an apb master on sys_clk_in, asynchronous field pins, and
 warning_in and position_in driven from sys_clk_in logic.
*/
`timescale 1ns/100ps
`default_nettype none
`include "shs_defines.svh"
module shs_top #(
   parameter int unsigned CYC_PER_US = `SHS_CYC_PER_US,
   parameter int unsigned US_PER_MS  = `SHS_US_PER_MS
) (
   // clock and reset
   input  wire logic               sys_clk_in,
   input  wire logic               rst_n_in,
   // apb slave
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [7:0]         paddr_in,
   input  wire logic [31:0]        pwdata_in,
   output logic      [31:0]        prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   // host and field pins
   input  wire logic               homing_go_input_in,
   input  wire logic               servo_on_input_in,
   input  wire logic               reference_detector_in,
   input  wire logic               counterclockwise_limit_input_in,
   input  wire logic               clockwise_limit_input_in,
   input  wire logic               index_pulse_in,
   // drive internals
   input  wire logic               warning_in,
   input  wire logic [31:0]        position_in,
   // drive controls
   output shs_pkg::shs_speed_t     speed_command_out,
   output logic                    clear_position_out,
   output logic                    clear_deviation_out,
   output logic                    homing_done_out,
   output logic                    homing_busy_out,
   output logic                    normal_cmd_enable_out,
   output logic                    ccw_limit_suspend_out,
   output logic                    cw_limit_suspend_out
);
   import shs_pkg::*;

   shs_state_t             st_q;
   shs_state_t             st_d;
   logic [`SHS_NPIN-1:0]   pin_s;
   logic [`SHS_NPIN-1:0]   rise;
   logic [`SHS_NPIN-1:0]   fall;
   logic                   go_s;
   logic                   son_s;
   logic                   us_tick;
   logic                   ms_tick;
   logic                   abort;
   logic                   start;
   logic                   ref_hit;
   logic                   setup;
   logic                   wr;
   logic                   up;
   shs_speed_t             tgt;
   logic [14:0]            rt;
   logic signed [31:0]     off;

   function automatic logic [12:0] shs_mag(input shs_speed_t v);
      shs_mag = v[12] ? 13'(-v) : 13'(v);
   endfunction

   function automatic logic signed [31:0] shs_offset(
      input logic [15:0] hi,
      input logic [15:0] lo
   );
      logic signed [31:0] u;
      u = 32'(signed'(hi));
      shs_offset = 32'(u * `SHS_OFF_SCALE) + 32'(signed'(lo));
   endfunction

   // edges from synced samples only
   assign pin_s = st_q.sync2;
   assign rise  = pin_s & ~st_q.prev;
   assign fall  = ~pin_s & st_q.prev;
   assign go_s  = pin_s[`SHS_P_GO];
   assign son_s = pin_s[`SHS_P_SON];
   assign off   = shs_offset(st_q.offu, st_q.offl);
   assign setup = psel_in & ~penable_in;
   assign wr    = psel_in & penable_in & pwrite_in & st_q.pready & ~st_q.pslverr;

   always_comb begin
      st_d = st_q;
      st_d.sync1 = {index_pulse_in, clockwise_limit_input_in,
                    counterclockwise_limit_input_in, reference_detector_in,
                    servo_on_input_in, homing_go_input_in};
      st_d.sync2 = st_q.sync1;
      st_d.prev  = st_q.sync2;
      st_d.clr   = 1'b0;
      tgt        = '0;
      rt         = '0;
      up         = 1'b0;
      start      = 1'b0;
      ref_hit    = 1'b0;

      // microsecond and millisecond ticks
      us_tick = st_q.us_cnt == 7'(CYC_PER_US - 1);
      ms_tick = us_tick && (st_q.ms_cnt == 10'(US_PER_MS - 1));
      st_d.us_cnt = us_tick ? '0 : 7'(st_q.us_cnt + 7'h01);
      if (us_tick) begin
         st_d.ms_cnt = ms_tick ? '0 : 10'(st_q.ms_cnt + 10'h001);
      end

      // apb: answer prepared in setup, taken in access
      st_d.pready  = setup;
      st_d.pslverr = 1'b0;
      if (setup) begin
         st_d.prdata = '0;
         unique case (paddr_in)
            `SHS_A_CTRL: begin
               st_d.prdata[`SHS_F_TRIG]   = st_q.trig;
               st_d.prdata[`SHS_F_REFM]   = st_q.refm;
               st_d.prdata[`SHS_F_ORGM]   = st_q.orgm;
               st_d.prdata[`SHS_F_RESUME] = st_q.resume;
            end
            `SHS_A_SPEED: begin
               st_d.prdata[`SHS_F_LO] = st_q.spd1;
               st_d.prdata[`SHS_F_HI] = st_q.spd2;
            end
            `SHS_A_RAMP: begin
               st_d.prdata[`SHS_F_RLO] = st_q.acc;
               st_d.prdata[`SHS_F_RHI] = st_q.dec;
            end
            `SHS_A_DELAY: begin
               st_d.prdata[`SHS_F_LO] = st_q.dly;
            end
            `SHS_A_OFFSET: begin
               st_d.prdata[`SHS_F_OLO] = st_q.offu;
               st_d.prdata[`SHS_F_OHI] = st_q.offl;
            end
            `SHS_A_STATUS: begin
               st_d.prdata[`SHS_F_FLAGS] = {st_q.auto_used, st_q.cw_sup,
                                            st_q.ccw_sup, st_q.cmd_en,
                                            st_q.busy, st_q.done};
               st_d.prdata[`SHS_F_FSM]   = st_q.state;
               st_d.prdata[`SHS_F_SPD]   = st_q.speed;
            end
            `SHS_A_ORIGIN: begin
               st_d.prdata = st_q.origin;
            end
            default: begin
               st_d.pslverr = 1'b1;
            end
         endcase
      end
      if (wr) begin
         unique case (paddr_in)
            `SHS_A_CTRL: begin
               st_d.trig   = pwdata_in[`SHS_F_TRIG];
               st_d.refm   = pwdata_in[`SHS_F_REFM];
               st_d.orgm   = pwdata_in[`SHS_F_ORGM];
               st_d.resume = pwdata_in[`SHS_F_RESUME];
            end
            `SHS_A_SPEED: begin
               st_d.spd1 = pwdata_in[`SHS_F_LO];
               st_d.spd2 = pwdata_in[`SHS_F_HI];
            end
            `SHS_A_RAMP: begin
               st_d.acc = pwdata_in[`SHS_F_RLO];
               st_d.dec = pwdata_in[`SHS_F_RHI];
            end
            `SHS_A_DELAY: begin
               st_d.dly = pwdata_in[`SHS_F_LO];
            end
            `SHS_A_OFFSET: begin
               st_d.offu = pwdata_in[`SHS_F_OLO];
               st_d.offl = pwdata_in[`SHS_F_OHI];
            end
            default: begin
            end
         endcase
      end

      // any servo-on since reset uses up the automatic run
      if (son_s) begin
         st_d.auto_used = 1'b1;
      end
      abort = ~son_s | warning_in;
      if (st_q.trig == `SHS_TRIG_LEVEL) begin
         abort = abort | ~go_s;
      end
      unique case (st_q.trig)
         `SHS_TRIG_OFF:   start = 1'b0;
         `SHS_TRIG_LEVEL: start = go_s;
         `SHS_TRIG_EDGE:  start = rise[`SHS_P_GO];
         `SHS_TRIG_AUTO:  start = ~st_q.auto_used;
      endcase
      unique case (st_q.refm)
         3'h0, 3'h1: ref_hit = rise[`SHS_P_REF];
         3'h2:       ref_hit = fall[`SHS_P_COUNTERCLOCKWISE_LIMIT_INPUT];
         3'h3:       ref_hit = fall[`SHS_P_CWL];
         3'h4, 3'h5: ref_hit = rise[`SHS_P_IDX];
         default:    ref_hit = 1'b0;
      endcase

      unique case (st_q.state)
         SHS_IDLE: begin
            if (start && son_s && !warning_in && st_q.refm <= `SHS_REF_MAX) begin
               st_d.state = SHS_REF;
               // odd modes seek clockwise
               st_d.dir   = st_q.refm[0];
            end
         end
         SHS_REF: begin
            if (abort) begin
               st_d.state = SHS_IDLE;
            end else if (ref_hit) begin
               if (st_q.orgm == `SHS_ORG_BACK) begin
                  st_d.state = SHS_ORG;
                  st_d.dir   = ~st_q.dir;
               end else if (st_q.orgm == `SHS_ORG_FWD) begin
                  st_d.state = SHS_ORG;
               end else begin
                  st_d.state = SHS_CLEAR;
               end
            end
         end
         SHS_ORG: begin
            if (abort) begin
               st_d.state = SHS_IDLE;
            end else if (rise[`SHS_P_IDX]) begin
               st_d.state = SHS_CLEAR;
            end
         end
         SHS_CLEAR: begin
            if (abort) begin
               st_d.state = SHS_IDLE;
            end else begin
               st_d.clr     = 1'b1;
               st_d.origin  = 32'(position_in + off);
               st_d.state   = SHS_DONE;
               st_d.us_cnt  = '0;
               st_d.ms_cnt  = '0;
               st_d.dly_cnt = '0;
            end
         end
         SHS_DONE: begin
            if (st_q.trig == `SHS_TRIG_LEVEL) begin
               if (!go_s) begin
                  st_d.state = SHS_IDLE;
               end
            end else if (ms_tick) begin
               st_d.dly_cnt = 12'(st_q.dly_cnt + 12'h001);
               if (st_d.dly_cnt >= st_q.dly) begin
                  st_d.state = SHS_IDLE;
               end
            end
         end
         default: begin
            st_d.state = SHS_IDLE;
         end
      endcase

      st_d.busy    = (st_d.state == SHS_REF) || (st_d.state == SHS_ORG) ||
                     (st_d.state == SHS_CLEAR);
      // done follows the clear pulse by one cycle
      st_d.done    = (st_q.state == SHS_DONE) && (st_d.state == SHS_DONE);
      st_d.cmd_en  = (st_d.state == SHS_IDLE) ||
                     ((st_d.state == SHS_DONE) && st_q.resume);
      st_d.ccw_sup = st_d.busy && (st_q.refm == 3'h2);
      st_d.cw_sup  = st_d.busy && (st_q.refm == 3'h3);

      // speed ramp, one r/min per acc or dec microseconds
      if (st_q.state == SHS_REF) begin
         tgt = st_q.dir ? 13'(st_q.spd1) : 13'(-13'(st_q.spd1));
      end else if (st_q.state == SHS_ORG) begin
         tgt = st_q.dir ? 13'(st_q.spd2) : 13'(-13'(st_q.spd2));
      end
      up = ((tgt[12] == st_q.speed[12]) || (st_q.speed == '0)) &&
           (shs_mag(tgt) > shs_mag(st_q.speed));
      rt = up ? st_q.acc : st_q.dec;
      if (st_q.speed == tgt) begin
         st_d.ramp_cnt = '0;
      end else if (rt == '0) begin
         st_d.speed    = tgt;
         st_d.ramp_cnt = '0;
      end else if (us_tick) begin
         if (st_q.ramp_cnt >= 15'(rt - 15'h0001)) begin
            st_d.ramp_cnt = '0;
            st_d.speed    = (tgt > st_q.speed) ? 13'(st_q.speed + 13'sh0001)
                                               : 13'(st_q.speed - 13'sh0001);
         end else begin
            st_d.ramp_cnt = 15'(st_q.ramp_cnt + 15'h0001);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st_q        <= '0;
         st_q.spd1   <= `SHS_RST_SPD1;
         st_q.spd2   <= `SHS_RST_SPD2;
         st_q.dly    <= `SHS_RST_DLY;
         st_q.cmd_en <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_out            = st_q.prdata;
   assign pready_out            = st_q.pready;
   assign pslverr_out           = st_q.pslverr;
   assign speed_command_out     = st_q.speed;
   assign clear_position_out    = st_q.clr;
   assign clear_deviation_out   = st_q.clr;
   assign homing_done_out       = st_q.done;
   assign homing_busy_out       = st_q.busy;
   assign normal_cmd_enable_out = st_q.cmd_en;
   assign ccw_limit_suspend_out = st_q.ccw_sup;
   assign cw_limit_suspend_out  = st_q.cw_sup;

   default clocking shs_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_off_ignored;
      (st_q.state == SHS_IDLE && st_q.trig == `SHS_TRIG_OFF) |=> st_q.state == SHS_IDLE;
   endproperty
   a_off_ignored: assert property (p_off_ignored) else $error("homing ran while off");

   property p_level_start;
      (st_q.state == SHS_IDLE && st_q.trig == `SHS_TRIG_LEVEL && go_s && son_s &&
       !warning_in && st_q.refm <= `SHS_REF_MAX) |=> st_q.busy ##1 !st_q.cmd_en;
   endproperty
   a_level_start: assert property (p_level_start) else $error("level start missed");

   property p_edge_start;
      (st_q.state == SHS_IDLE && st_q.trig == `SHS_TRIG_EDGE && !rise[`SHS_P_GO])
         |=> st_q.state == SHS_IDLE;
   endproperty
   a_edge_start: assert property (p_edge_start) else $error("start without edge");

   property p_auto_once;
      (st_q.state == SHS_IDLE && st_q.trig == `SHS_TRIG_AUTO && st_q.auto_used)
         |=> st_q.state == SHS_IDLE;
   endproperty
   a_auto_once: assert property (p_auto_once) else $error("auto homing repeated");

   property p_son_gate;
      $rose(st_q.busy) |-> $past(son_s) && !st_q.cmd_en;
   endproperty
   a_son_gate: assert property (p_son_gate) else $error("start without servo-on");

   property p_direct;
      (st_q.state == SHS_REF && ref_hit && !abort && st_q.orgm == 2'h2)
         |=> st_q.state == SHS_CLEAR ##1 st_q.clr;
   endproperty
   a_direct: assert property (p_direct) else $error("direct origin not taken");

   property p_clear_done;
      $rose(st_q.clr) |-> !st_q.done ##1 st_q.done;
   endproperty
   a_clear_done: assert property (p_clear_done) else $error("done not after clear");

   property p_level_hold;
      (st_q.done && st_q.trig == `SHS_TRIG_LEVEL && go_s) |=> st_q.done;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("done dropped early");

   property p_hold_cmd;
      (st_q.done && !st_q.resume) |-> !st_q.cmd_en && st_q.speed == '0;
   endproperty
   a_hold_cmd: assert property (p_hold_cmd) else $error("commands taken at origin");

   property p_abort;
      (st_q.busy && (!son_s || warning_in)) |=> !st_q.busy && !st_q.done;
   endproperty
   a_abort: assert property (p_abort) else $error("abort ignored");

   property p_origin;
      $rose(st_q.clr) |-> st_q.origin == 32'($past(position_in) + $past(off));
   endproperty
   a_origin: assert property (p_origin) else $error("origin offset wrong");

   property p_ramp;
      (st_q.acc != '0 && st_q.dec != '0) |=> (st_q.speed == $past(st_q.speed)) ||
         (st_q.speed == 13'($past(st_q.speed) + 13'sh0001)) ||
         (st_q.speed == 13'($past(st_q.speed) - 13'sh0001));
   endproperty
   a_ramp: assert property (p_ramp) else $error("speed stepped");
endmodule
`default_nettype wire

//--- tb/shs_host_model.sv
/*
 shs_host_model.sv: host controller model that drives go and servo-on.
 Assumes it shares sys_clk_in with the homing sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module shs_host_model (
   // clock
   input  wire logic sys_clk_in,
   // bench requests
   input  wire logic want_go_in,
   input  wire logic want_son_in,
   input  wire logic level_mode_in,
   // drive status
   input  wire logic busy_in,
   // pins to the drive
   output logic      go_out = 1'h0,
   output logic      son_out = 1'h0
);
   // level mode keeps go up while homing runs
   always_ff @(posedge sys_clk_in) begin
      go_out  <= want_go_in | (level_mode_in & busy_in);
      son_out <= want_son_in;
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
 tb_top.sv: self-checking bench of the homing sequencer.
 Assumes shs_pkg, shs_top and shs_host_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "shs_defines.svh"
module tb_top;
   import shs_pkg::*;
   localparam int MSC = 4;
   logic        sys_clk_in = 1'h0, rst_n_in = 1'h0, want_go = 1'h0, want_son = 1'h0;
   logic        psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0, lvl = 1'h0;
   logic [7:0]  paddr_in = 8'h0, c;
   logic [31:0] pwdata_in = 32'h0, position_in = 32'h0, prdata_out, rd;
   logic        pready_out, pslverr_out, homing_go_input_in, servo_on_input_in, err;
   logic        reference_detector_in = 1'h0, counterclockwise_limit_input_in = 1'h1;
   logic        clockwise_limit_input_in = 1'h1, index_pulse_in = 1'h0, warning_in = 1'h0;
   logic        clear_position_out, clear_deviation_out, homing_done_out;
   logic        homing_busy_out, normal_cmd_enable_out;
   logic        ccw_limit_suspend_out, cw_limit_suspend_out;
   shs_speed_t  speed_command_out;
   logic [11:0] s1, s2;
   logic [15:0] ou, ol;
   int          n_mismatch = 0, check_count = 0, cyc = 0, n;
   logic [7:0]  tbl [7] = '{8'h42, 8'hD1, 8'h0A, 8'h8E, 8'h21, 8'h56, 8'h06};

   shs_top #(.CYC_PER_US(2), .US_PER_MS(2)) DUT (
      .sys_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .homing_go_input_in, .servo_on_input_in,
      .reference_detector_in, .counterclockwise_limit_input_in,
      .clockwise_limit_input_in, .index_pulse_in, .warning_in, .position_in,
      .speed_command_out, .clear_position_out, .clear_deviation_out, .homing_done_out,
      .homing_busy_out, .normal_cmd_enable_out, .ccw_limit_suspend_out,
      .cw_limit_suspend_out);
   shs_host_model HOST (.sys_clk_in, .want_go_in(want_go), .want_son_in(want_son),
      .level_mode_in(lvl), .busy_in(homing_busy_out), .go_out(homing_go_input_in),
      .son_out(servo_on_input_in));

   initial begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 32'h4E20) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge sys_clk_in);
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk_in);
      psel_in    <= 1'h1;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'h1;
      do @(posedge sys_clk_in); while (pready_out !== 1'h1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'h0;
      penable_in <= 1'h0;
   endtask
   function automatic logic sig(int s);
      case (s)
         0: return homing_busy_out;
         1: return clear_position_out;
         default: return homing_done_out;
      endcase
   endfunction
   task automatic wt(int s, logic v);
      n = 0;
      while (sig(s) !== v && n < 500) begin
         @(posedge sys_clk_in);
         n++;
      end
   endtask
   function automatic int pin(logic [2:0] r);
      return (r < 3'h2) ? 0 : (r == 3'h2) ? 1 : (r == 3'h3) ? 2 : 3;
   endfunction
   function automatic logic [31:0] exp_org(logic [31:0] p, logic [15:0] u, logic [15:0] l);
      int su;
      int sl;
      su = $signed(u);
      sl = $signed(l);
      return p + 32'(su * 32'sh2710 + sl);
   endfunction
   // 0 detector rise, 1 ccw limit fall, 2 cw limit fall, 3 index pulse
   task automatic hit(int p);
      @(posedge sys_clk_in);
      case (p)
         0: reference_detector_in <= 1'h1;
         1: counterclockwise_limit_input_in <= 1'h0;
         2: clockwise_limit_input_in <= 1'h0;
         default: index_pulse_in <= 1'h1;
      endcase
      tick(3);
      reference_detector_in <= 1'h0;
      counterclockwise_limit_input_in <= 1'h1;
      clockwise_limit_input_in <= 1'h1;
      index_pulse_in <= 1'h0;
   endtask
   task automatic cfg(logic [7:0] ctrl);
      s1 = 12'(1 + $urandom_range(2999));
      s2 = 12'(1 + $urandom_range(2999));
      ou = 16'($urandom);
      ol = 16'($urandom_range(19998) - 9999);
      apb(1'h1, `SHS_A_SPEED, {4'h0, s2, 4'h0, s1});
      apb(1'h1, `SHS_A_OFFSET, {ol, ou});
      apb(1'h1, `SHS_A_DELAY, 32'h3);
      apb(1'h1, `SHS_A_CTRL, {24'h0, ctrl});
      position_in <= $urandom;
   endtask
   task automatic start(logic lv, shs_speed_t sp);
      want_go <= 1'h1;
      wt(0, 1'h1);
      chk("busy", homing_busy_out, 1'h1);
      chk("cmd_off", normal_cmd_enable_out, 1'h0);
      want_go <= lv;
      tick(3);
      chk("speed1", speed_command_out, sp);
   endtask
   task automatic finish(int p, logic lv, logic m);
      hit(p);
      wt(1, 1'h1);
      chk("clr_dev", clear_deviation_out, 1'h1);
      chk("clr_pos", clear_position_out, 1'h1);
      chk("done_early", homing_done_out, 1'h0);
      tick(1);
      chk("done", homing_done_out, 1'h1);
      chk("cmd_done", normal_cmd_enable_out, m);
      apb(1'h0, `SHS_A_ORIGIN, 32'h0);
      chk("origin", rd, exp_org(position_in, ou, ol));
      if (lv) begin
         tick(10);
         chk("done_hold", homing_done_out, 1'h1);
         want_go <= 1'h0;
         wt(2, 1'h0);
         chk("done_go", n < 6, 1'h1);
      end else begin
         wt(2, 1'h0);
         chk("done_dly", n >= 2 * MSC && n <= 4 * MSC, 1'h1);
      end
      tick(2);
      chk("cmd_back", normal_cmd_enable_out, 1'h1);
      chk("sup_off", {ccw_limit_suspend_out, cw_limit_suspend_out}, 2'h0);
   endtask

   initial begin
      n = $urandom(32'h962DE417);
      tick(10);
      rst_n_in <= 1'h1;
      want_son <= 1'h1;
      apb(1'h0, `SHS_A_SPEED, 32'h0);
      chk("speed_rst", rd, 32'h003201F4);
      apb(1'h0, `SHS_A_DELAY, 32'h0);
      chk("delay_rst", rd, 32'h64);
      apb(1'h1, 8'h1C, 32'hFFFF);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      cfg(8'h40);
      want_go <= 1'h1;
      tick(10);
      chk("off_busy", homing_busy_out, 1'h0);
      apb(1'h0, `SHS_A_STATUS, 32'h0);
      chk("status", rd, 32'h24);
      want_go <= 1'h0;
      foreach (tbl[i]) begin
         c = tbl[i];
         cfg(c);
         lvl <= (c[1:0] == 2'h1);
         start(c[1:0] == 2'h1, c[2] ? shs_speed_t'(s1) : -shs_speed_t'(s1));
         chk("ccw_sup", ccw_limit_suspend_out, c[4:2] == 3'h2);
         chk("cw_sup", cw_limit_suspend_out, c[4:2] == 3'h3);
         if (c[6:5] != 2'h2) begin
            hit(pin(c[4:2]));
            tick(6);
            chk("speed2", speed_command_out, (c[2] ^ (c[6:5] == 2'h0)) ?
                shs_speed_t'(s2) : -shs_speed_t'(s2));
         end
         finish((c[6:5] == 2'h2) ? pin(c[4:2]) : 3, c[1:0] == 2'h1, c[7]);
      end
      // warning, servo-off, then go dropped in level mode
      for (int k = 0; k < 3; k++) begin
         cfg(k ? 8'h41 : 8'h42);
         lvl <= k > 0;
         start(k > 0, -shs_speed_t'(s1));
         if (k == 1) want_son <= 1'h0;
         else if (k == 2) {lvl, want_go} <= 2'h0;
         else warning_in <= 1'h1;
         wt(0, 1'h0);
         chk("abort", n, k ? 5 : 2);
         tick(4);
         chk("abort_done", homing_done_out, 1'h0);
         want_go <= 1'h0;
         want_son <= 1'h1;
         warning_in <= 1'h0;
         lvl <= 1'h0;
         tick(5);
      end
      // one r/min step per microsecond: ten steps in twenty cycles
      apb(1'h1, `SHS_A_RAMP, 32'h00010001);
      cfg(8'h42);
      want_go <= 1'h1;
      wt(0, 1'h1);
      want_go <= 1'h0;
      tick(20);
      chk("ramp", -speed_command_out < 12 && speed_command_out < 0, 1'h1);
      rst_n_in <= 1'h0;
      want_son <= 1'h0;
      tick(3);
      rst_n_in <= 1'h1;
      cfg(8'h47);
      want_son <= 1'h1;
      wt(0, 1'h1);
      chk("auto_busy", homing_busy_out, 1'h1);
      finish(0, 1'h0, 1'h0);
      want_son <= 1'h0;
      tick(5);
      want_son <= 1'h1;
      tick(20);
      chk("auto_again", homing_busy_out, 1'h0);
      complete_run();
   end
endmodule
`default_nettype wire
